// ---- eew_target.v ----
// Purpose: Two-wire serial EEPROM target, 8192 x 8, with page write path
// Assumes: scl and sda pins are asynchronous to mclk; each scl phase lasts at least four mclk cycles
// Notes:   Array is flip-flop free of vendor cells; programming copies the page buffer
`timescale 1ns/100ps
`default_nettype none
`include "eew_defines.vh"
module eew_target #(
  parameter [31:0] PROG_CYC = `EEW_PROG_CYCLES   // Program cycle length in mclk cycles
) (
  input  wire       mclk,              // Core clock, 50 MHz
  input  wire       sys_rst,           // Synchronous reset, active high
  input  wire       scl_in,            // Serial clock pin
  input  wire       sda_in,            // Serial data pin level
  output reg        sda_out,           // Serial data output value, always 0
  output reg        sda_oe_n,          // Low while pulling sda low
  input  wire       chip_select_bit0,  // Strap, pulled low outside
  input  wire       chip_select_bit1,  // Strap, pulled low outside
  input  wire       chip_select_bit2,  // Strap, pulled low outside
  input  wire       write_protect,     // High protects the whole array
  output reg        prog_busy          // Self-timed program cycle running
);
  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  localparam [5:0] ST_IDLE = 6'h01;
  localparam [5:0] ST_RX   = 6'h02;
  localparam [5:0] ST_ACK  = 6'h04;
  localparam [5:0] ST_TX   = 6'h08;
  localparam [5:0] ST_MACK = 6'h10;
  localparam [5:0] ST_PROG = 6'h20;

  localparam [1:0] PH_DEV = 2'h0;
  localparam [1:0] PH_AHI = 2'h1;
  localparam [1:0] PH_ALO = 2'h2;
  localparam [1:0] PH_DAT = 2'h3;

  localparam [22:0] PROG_LAST = PROG_CYC[22:0] - 23'h000001;

  // ----------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------------------------------
  reg scl_s1_reg, scl_s2_reg, scl_d_reg;
  reg sda_s1_reg, sda_s2_reg, sda_d_reg;
  reg [2:0] cs_s1_reg, cs_s2_reg;
  reg wp_s1_reg, wp_s2_reg;
  // Idle-high reset values keep a false edge from following reset

  always @(posedge mclk) begin
    if (sys_rst) begin
      scl_s1_reg <= 1'b1;
      scl_s2_reg <= 1'b1;
      scl_d_reg  <= 1'b1;
      sda_s1_reg <= 1'b1;
      sda_s2_reg <= 1'b1;
      sda_d_reg  <= 1'b1;
      cs_s1_reg  <= 3'h0;
      cs_s2_reg  <= 3'h0;
      wp_s1_reg  <= 1'b0;
      wp_s2_reg  <= 1'b0;
    end else begin
      scl_s1_reg <= scl_in;
      scl_s2_reg <= scl_s1_reg;
      scl_d_reg  <= scl_s2_reg;
      sda_s1_reg <= sda_in;
      sda_s2_reg <= sda_s1_reg;
      sda_d_reg  <= sda_s2_reg;
      cs_s1_reg  <= {chip_select_bit2, chip_select_bit1, chip_select_bit0};
      cs_s2_reg  <= cs_s1_reg;
      wp_s1_reg  <= write_protect;
      wp_s2_reg  <= wp_s1_reg;
    end
  end

  // Start and stop need scl high on both samples around the sda edge
  wire scl_rise = scl_s2_reg & ~scl_d_reg;
  wire scl_fall = ~scl_s2_reg & scl_d_reg;
  wire start_ev = scl_s2_reg & scl_d_reg & sda_d_reg & ~sda_s2_reg;
  wire stop_ev  = scl_s2_reg & scl_d_reg & ~sda_d_reg & sda_s2_reg;

  // ----------------------------------------------------------------
  // Address helpers
  // ----------------------------------------------------------------
  // Only the page offset bits count; the page number stays
  function [`EEW_ADDR_W-1:0] page_inc;
    input [`EEW_ADDR_W-1:0] a;
    begin
      page_inc = {a[`EEW_ADDR_W-1:`EEW_PAGE_OFF_W], a[`EEW_PAGE_OFF_W-1:0] + 5'h01};
    end
  endfunction

  // ----------------------------------------------------------------
  // Direction decode
  // ----------------------------------------------------------------
  function dir_is_read;
    input [7:0] w;
    begin
      dir_is_read = (w[0] != `EEW_RD_BIT);
    end
  endfunction

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  reg [5:0]              state_reg;
  reg [1:0]              phase_reg;
  reg [3:0]              bit_cnt_reg;
  reg [7:0]              shift_reg;
  reg                    ack_low_reg;
  reg                    is_read_reg;
  reg [`EEW_ADDR_W-1:0]  addr_reg;
  reg [`EEW_ADDR_W-1:0]  page_base_reg;
  reg                    have_data_reg;
  reg [22:0]             prog_cnt_reg;
  reg [`EEW_PAGE_OFF_W:0] copy_idx_reg;

  reg [7:0] mem [0:(1<<`EEW_ADDR_W)-1];

  wire [7:0] rx_byte = {shift_reg[6:0], sda_s2_reg};
  wire       dev_hit = (rx_byte[7:4] == `EEW_TYPE_CODE) &&
                       (rx_byte[3:1] == cs_s2_reg);

  // Page buffer
  // Valid mask cleared on each start outside the program cycle, so only this transaction programs
  reg                        pb_clr;
  reg                        pb_wr;
  wire [7:0]                 pb_rd_data;
  wire                       pb_rd_valid;

  eew_page_buf u_page_buf (
    .mclk     (mclk),
    .sys_rst  (sys_rst),
    .clr      (pb_clr),
    .wr_en    (pb_wr),
    .wr_idx   (addr_reg[`EEW_PAGE_OFF_W-1:0]),
    .wr_data  (rx_byte),
    .rd_idx   (copy_idx_reg[`EEW_PAGE_OFF_W-1:0]),
    .rd_data  (pb_rd_data),
    .rd_valid (pb_rd_valid)
  );

  always @* begin
    pb_clr = start_ev && (state_reg != ST_PROG);
    pb_wr  = (state_reg == ST_RX) && scl_rise && (bit_cnt_reg == 4'h7) &&
             (phase_reg == PH_DAT) && !wp_s2_reg;
  end

  // ----------------------------------------------------------------
  // Array write during the program cycle
  // ----------------------------------------------------------------
  always @(posedge mclk) begin
    if (state_reg == ST_PROG && !copy_idx_reg[`EEW_PAGE_OFF_W] && pb_rd_valid)
      mem[{page_base_reg[`EEW_ADDR_W-1:`EEW_PAGE_OFF_W],
           copy_idx_reg[`EEW_PAGE_OFF_W-1:0]}] <= pb_rd_data;
  end

  // ----------------------------------------------------------------
  // Main sequencer
  // ----------------------------------------------------------------
  always @(posedge mclk) begin
    if (sys_rst) begin
      state_reg     <= ST_IDLE;
      phase_reg     <= PH_DEV;
      bit_cnt_reg   <= 4'h0;
      shift_reg     <= 8'h00;
      ack_low_reg   <= 1'b0;
      is_read_reg   <= 1'b0;
      addr_reg      <= {`EEW_ADDR_W{1'b0}};
      page_base_reg <= {`EEW_ADDR_W{1'b0}};
      have_data_reg <= 1'b0;
      prog_cnt_reg  <= 23'h000000;
      copy_idx_reg  <= 6'h00;
      sda_out       <= 1'b0;
      sda_oe_n      <= 1'b1;
      prog_busy     <= 1'b0;
    end else if (state_reg == ST_PROG) begin
      // Bus is ignored until the cycle ends
      // Copy runs first, one offset per cycle, well inside the count
      sda_oe_n <= 1'b1;
      if (!copy_idx_reg[`EEW_PAGE_OFF_W])
        copy_idx_reg <= copy_idx_reg + 6'h01;
      if (prog_cnt_reg == PROG_LAST) begin
        state_reg <= ST_IDLE;
        prog_busy <= 1'b0;
      end else begin
        prog_cnt_reg <= prog_cnt_reg + 23'h000001;
      end
    end else if (start_ev) begin
      state_reg   <= ST_RX;
      phase_reg   <= PH_DEV;
      bit_cnt_reg <= 4'h0;
      sda_oe_n    <= 1'b1;
      have_data_reg <= 1'b0;
    end else if (stop_ev) begin
      // Only a write that collected data starts programming
      sda_oe_n <= 1'b1;
      if (!is_read_reg && have_data_reg && state_reg != ST_IDLE) begin
        state_reg    <= ST_PROG;
        prog_busy    <= 1'b1;
        prog_cnt_reg <= 23'h000000;
        copy_idx_reg <= 6'h00;
      end else begin
        state_reg <= ST_IDLE;
      end
    end else begin
      case (state_reg)
        ST_IDLE: begin
          sda_oe_n <= 1'b1;
        end
        ST_RX: begin
          // Bits enter msb first on scl rise
          if (scl_rise) begin
            shift_reg   <= rx_byte;
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            if (bit_cnt_reg == 4'h7) begin
              bit_cnt_reg <= 4'h0;
              state_reg   <= ST_ACK;
              ack_low_reg <= 1'b1;
              case (phase_reg)
                PH_DEV: begin
                  is_read_reg <= dir_is_read(rx_byte);
                  if (!dev_hit) begin
                    state_reg <= ST_IDLE;
                  end else if (dir_is_read(rx_byte)) begin
                    shift_reg <= mem[addr_reg];
                  end else begin
                    phase_reg <= PH_AHI;
                  end
                end
                PH_AHI: begin
                  addr_reg[`EEW_ADDR_W-1:8] <= rx_byte[4:0];
                  phase_reg <= PH_ALO;
                end
                PH_ALO: begin
                  addr_reg[7:0] <= rx_byte;
                  phase_reg     <= PH_DAT;
                end
                PH_DAT: begin
                  // Protected data is refused and never buffered
                  if (wp_s2_reg) begin
                    ack_low_reg <= 1'b0;
                  end else begin
                    have_data_reg <= 1'b1;
                    page_base_reg <= addr_reg;
                    addr_reg      <= page_inc(addr_reg);
                  end
                end
                default: phase_reg <= PH_DEV;
              endcase
            end
          end
        end
        ST_ACK: begin
          // First fall places the ack bit, second fall ends the ninth clock
          if (scl_fall) begin
            if (bit_cnt_reg == 4'h0) begin
              bit_cnt_reg <= 4'h1;
              sda_oe_n    <= ~ack_low_reg;
            end else begin
              bit_cnt_reg <= 4'h0;
              ack_low_reg <= 1'b0;
              if (is_read_reg) begin
                state_reg <= ST_TX;
                sda_oe_n  <= shift_reg[7];
              end else begin
                state_reg <= ST_RX;
                sda_oe_n  <= 1'b1;
              end
            end
          end
        end
        ST_TX: begin
          // Next bit after each fall; release after the eighth
          if (scl_fall) begin
            if (bit_cnt_reg == 4'h7) begin
              sda_oe_n    <= 1'b1;
              state_reg   <= ST_MACK;
              addr_reg    <= addr_reg + 13'h0001;
            end else begin
              sda_oe_n    <= shift_reg[6];
              shift_reg   <= {shift_reg[6:0], 1'b1};
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
          end
        end
        ST_MACK: begin
          // Controller ack low asks for the next byte
          sda_oe_n <= 1'b1;
          if (scl_rise) begin
            if (!sda_s2_reg) begin
              shift_reg   <= mem[addr_reg];
              bit_cnt_reg <= 4'h1;
              state_reg   <= ST_ACK;
            end else begin
              state_reg <= ST_IDLE;
            end
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end
endmodule // eew_target
`default_nettype wire

// ---- eew_defines.vh ----
// Purpose: Shared constants of the serial EEPROM target write path
// Assumes: Core clock of 50 MHz
// Notes:   Included by both design files
`ifndef EEW_DEFINES_VH
`define EEW_DEFINES_VH
// Type code value is arbitrary
`define EEW_TYPE_CODE     4'h6
`define EEW_ADDR_W        13
`define EEW_PAGE_BYTES    32
`define EEW_PAGE_OFF_W    5
`define EEW_MCLK_KHZ      50000
`define EEW_PROG_TIME_MS  5
`define EEW_PROG_CYCLES   (`EEW_PROG_TIME_MS * `EEW_MCLK_KHZ)
// Shortened program count for simulation
`define EEW_SIM_PROG_CYCLES 200
`define EEW_RD_BIT        1'b0
`endif

// ---- eew_page_buf.v ----
// Purpose: Page write buffer of 32 bytes, flip-flop storage
// Assumes: Written one byte per cycle while a write is collected
// Notes:   Valid mask tracks which offsets belong to the current page write
`timescale 1ns/100ps
`default_nettype none
`include "eew_defines.vh"
module eew_page_buf (
  input  wire                        mclk,      // Core clock
  input  wire                        sys_rst,   // Synchronous reset
  input  wire                        clr,       // Clear valid mask
  input  wire                        wr_en,     // Store one byte
  input  wire [`EEW_PAGE_OFF_W-1:0]  wr_idx,    // Offset in page
  input  wire [7:0]                  wr_data,   // Byte to store
  input  wire [`EEW_PAGE_OFF_W-1:0]  rd_idx,    // Offset to read
  output wire [7:0]                  rd_data,   // Stored byte
  output wire                        rd_valid   // Offset holds new data
);
  reg [7:0]                 mem_reg [0:`EEW_PAGE_BYTES-1];
  reg [`EEW_PAGE_BYTES-1:0] vld_reg;
  integer i;

  always @(posedge mclk) begin
    if (sys_rst) begin
      vld_reg <= {`EEW_PAGE_BYTES{1'b0}};
      for (i = 0; i < `EEW_PAGE_BYTES; i = i + 1)
        mem_reg[i] <= 8'h00;
    end else begin
      if (clr)
        vld_reg <= {`EEW_PAGE_BYTES{1'b0}};
      else if (wr_en)
        vld_reg[wr_idx] <= 1'b1;
      if (wr_en)
        mem_reg[wr_idx] <= wr_data;
    end
  end

  assign rd_data  = mem_reg[rd_idx];
  assign rd_valid = vld_reg[rd_idx];
endmodule // eew_page_buf
`default_nettype wire

// ---- eew_checker.sv ----
// Purpose: Pin-level assertions on the serial EEPROM target
// Assumes: Program length handed in through the bind
// Notes:   Bound into every eew_target instance
`timescale 1ns/100ps
`default_nettype none
`include "eew_defines.vh"
module eew_checker #(parameter int PROG = `EEW_PROG_CYCLES) (
  input wire logic mclk,       // Core clock
  input wire logic sys_rst,    // Synchronous reset
  input wire logic scl_in,     // Bus clock pin
  input wire logic sda_in,     // Resolved data pin
  input wire logic sda_out,    // Open-drain value
  input wire logic sda_oe_n,   // Low while pulling
  input wire logic prog_busy   // Program cycle running
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // ----------------------------------------
  // Helper counters
  // ----------------------------------------
  logic [22:0] busy_cnt_reg;
  logic [3:0]  since_stop_reg;
  logic        sda_prev_reg;
  always_ff @(posedge mclk) begin
    sda_prev_reg <= sda_in;
    if (sys_rst) begin
      busy_cnt_reg   <= 23'h000000;
      since_stop_reg <= 4'hF;
    end else begin
      busy_cnt_reg   <= prog_busy ? busy_cnt_reg + 23'h000001 : 23'h000000;
      if (scl_in && sda_in && !sda_prev_reg)
        since_stop_reg <= 4'h0;
      else if (since_stop_reg != 4'hF)
        since_stop_reg <= since_stop_reg + 4'h1;
    end
  end
  sequence s_prog_start;
    $rose(prog_busy);
  endsequence
  sequence s_pull;
    $fell(sda_oe_n);
  endsequence
  property p_open_drain;
    sda_out == 1'b0;
  endproperty
  property p_change_scl_low;
    $changed(sda_oe_n) |-> !scl_in;
  endproperty
  property p_busy_quiet;
    prog_busy |-> sda_oe_n;
  endproperty
  property p_busy_after_stop;
    s_prog_start |-> since_stop_reg <= 4'hA;
  endproperty
  property p_busy_min;
    s_prog_start |=> prog_busy [*8];
  endproperty
  property p_busy_len;
    $fell(prog_busy) |-> busy_cnt_reg == 23'(PROG);
  endproperty
  property p_ack_hold;
    s_pull |=> !sda_oe_n [*4];
  endproperty
  property p_pull_ends;
    s_pull |-> ##[1:160] $rose(sda_oe_n);
  endproperty
  a_open_drain:      assert property (p_open_drain) else $error("sda driven high");
  a_change_scl_low:  assert property (p_change_scl_low) else $error("sda moved with scl high");
  a_busy_quiet:      assert property (p_busy_quiet) else $error("bus answered while busy");
  a_busy_after_stop: assert property (p_busy_after_stop) else $error("program without stop");
  a_busy_min:        assert property (p_busy_min) else $error("program cycle too short");
  a_busy_len:        assert property (p_busy_len) else $error("program length wrong");
  a_ack_hold:        assert property (p_ack_hold) else $error("pull released early");
  a_pull_ends:       assert property (p_pull_ends) else $error("sda held low too long");
endmodule // eew_checker
bind eew_target eew_checker #(.PROG(PROG_CYC)) u_chk (.mclk(mclk), .sys_rst(sys_rst), .scl_in(scl_in),
  .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe_n(sda_oe_n), .prog_busy(prog_busy));
`default_nettype wire

// ---- eew_ctl_model.sv ----
// Purpose: Behavioural two-wire bus controller
// Assumes: Each bus phase lasts HALF core cycles; 4 gives a 160 ns scl period
// Notes:   Released sda reads high through the pull-up
`timescale 1ns/100ps
`default_nettype none
module eew_ctl_model #(parameter int HALF = 4) (
  input  wire logic mclk,      // Core clock
  input  wire logic sda_line,  // Resolved sda wire
  output var  logic scl,       // Bus clock
  output var  logic sda_pull   // High pulls sda low
);
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  task automatic wait_h();
    repeat (HALF) @(negedge mclk);
  endtask
  task automatic clk_bit(input logic b, output logic r);
    @(negedge mclk) sda_pull = ~b;
    repeat (HALF - 1) @(negedge mclk);
    scl = 1'b1;
    wait_h();
    r = sda_line;
    scl = 1'b0;
  endtask
  task automatic bus_start();
    @(negedge mclk) sda_pull = 1'b0;
    wait_h();
    scl = 1'b1;
    wait_h();
    sda_pull = 1'b1;
    wait_h();
    scl = 1'b0;
  endtask
  task automatic bus_stop();
    @(negedge mclk) sda_pull = 1'b1;
    wait_h();
    scl = 1'b1;
    wait_h();
    sda_pull = 1'b0;
    wait_h();
  endtask
  task automatic send_byte(input logic [7:0] d, output logic ack);
    for (int i = 7; i >= 0; i--) clk_bit(d[i], ack);
    clk_bit(1'b1, ack);
  endtask
  task automatic recv_byte(input logic ack_lvl, output logic [7:0] d);
    logic r;
    for (int i = 0; i < 8; i++) begin
      clk_bit(1'b1, r);
      d = {d[6:0], r};
    end
    clk_bit(ack_lvl, r);
  endtask
endmodule // eew_ctl_model
`default_nettype wire

// ---- eew_target_tb.sv ----
// Purpose: Self-checking bench of the serial EEPROM target
// Assumes: Select straps set to 101
// Notes:   Bus traffic comes from eew_ctl_model
`timescale 1ns/100ps
`default_nettype none
`include "eew_defines.vh"
module eew_target_tb;
  localparam logic [7:0] dev_wr = {`EEW_TYPE_CODE, 3'b101, 1'b0};
  logic       mclk = 1'b0;
  logic       sys_rst = 1'b1;
  logic [2:0] straps = 3'b101;
  logic       wp = 1'b0;
  logic       scl, pull, sda_out, sda_oe_n, busy;
  wire        sda = ~pull & sda_oe_n;
  int         miscompares = 0;
  int         samples_checked = 0;
  always #10 mclk = ~mclk;
  eew_target #(.PROG_CYC(`EEW_SIM_PROG_CYCLES)) dut (.mclk(mclk), .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .chip_select_bit0(straps[0]), .chip_select_bit1(straps[1]),
    .chip_select_bit2(straps[2]), .write_protect(wp), .prog_busy(busy));
  eew_ctl_model ctl (.mclk(mclk), .sda_line(sda), .scl(scl), .sda_pull(pull));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic tx(input logic [7:0] d, input logic ea);
    logic a;
    ctl.send_byte(d, a);
    chk("ack", {7'h00, a}, {7'h00, ea});
  endtask
  task automatic wait_idle();
    int n;
    for (n = 0; n < 400 && busy !== 1'b0; n++) @(negedge mclk);
    if (n == 400) begin
      miscompares++;
      report_and_stop();
    end
  endtask
  task automatic sel_addr(input logic [12:0] a);
    ctl.bus_start();
    tx(dev_wr, 1'b0);
    tx({3'b111, a[12:8]}, 1'b0);
    tx(a[7:0], 1'b0);
  endtask
  task automatic rd1(input logic [12:0] a, output logic [7:0] d);
    sel_addr(a);
    ctl.bus_start();
    tx(dev_wr | 8'h01, 1'b0);
    ctl.recv_byte(1'b1, d);
    ctl.bus_stop();
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_byte_write();
    logic [7:0] d;
    sel_addr(13'h1234);
    tx(8'h5A, 1'b0);
    ctl.bus_stop();
    chk("busy", {7'h00, busy}, 8'h01);
    ctl.bus_start();
    tx(dev_wr, 1'b1);
    ctl.bus_stop();
    wait_idle();
    ctl.bus_start();
    tx(dev_wr, 1'b0);
    ctl.bus_stop();
    repeat (10) @(negedge mclk);
    chk("busy", {7'h00, busy}, 8'h00);
    rd1(13'h1234, d);
    chk("byte", d, 8'h5A);
  endtask
  task automatic t_page_wrap();
    logic [7:0] d;
    sel_addr(13'h005E);
    for (int i = 1; i <= 4; i++) tx(8'(i * 8'h11), 1'b0);
    ctl.bus_stop();
    wait_idle();
    sel_addr(13'h005E);
    ctl.bus_start();
    tx(dev_wr | 8'h01, 1'b0);
    ctl.recv_byte(1'b0, d);
    chk("seq0", d, 8'h11);
    ctl.recv_byte(1'b1, d);
    chk("seq1", d, 8'h22);
    ctl.bus_stop();
    rd1(13'h0041, d);
    chk("wrap", d, 8'h44);
    rd1(13'h0040, d);
    chk("wrap0", d, 8'h33);
  endtask
  task automatic t_protect();
    logic [7:0] d;
    @(negedge mclk) wp = 1'b1;
    sel_addr(13'h1234);
    tx(8'hA5, 1'b1);
    tx(8'h3C, 1'b1);
    ctl.bus_stop();
    chk("busy", {7'h00, busy}, 8'h00);
    rd1(13'h1234, d);
    chk("kept", d, 8'h5A);
    @(negedge mclk) wp = 1'b0;
  endtask
  task automatic t_select();
    for (int i = 0; i < 9; i++) begin
      ctl.bus_start();
      if (i < 8)
        tx({`EEW_TYPE_CODE, 3'(i), 1'b0}, i != 5);
      else
        tx({4'h5, 3'b101, 1'b0}, 1'b1);
      ctl.bus_stop();
    end
    @(negedge mclk) straps = 3'b000;
    ctl.bus_start();
    tx({`EEW_TYPE_CODE, 3'b000, 1'b0}, 1'b0);
    ctl.bus_stop();
    @(negedge mclk) straps = 3'b101;
    chk("sda_out", {7'h00, sda_out}, 8'h00);
  endtask
  initial begin
    repeat (5) @(negedge mclk);
    sys_rst = 1'b0;
    repeat (4) @(negedge mclk);
    t_byte_write();
    t_page_wrap();
    t_protect();
    t_select();
    report_and_stop();
  end
endmodule // eew_target_tb
`default_nettype wire
